// file: src/pps_pkg.sv
package pps_pkg;
    // Clock rate and millisecond tick
    localparam int CLK_HZ = 125000000;
    localparam int TICK_CYCLES = CLK_HZ / 1000;
    // Sink delays in milliseconds
    localparam int BLACK_MIN_MS = 1;       // 0.5 ms rounded up to whole ms ticks
    localparam int BLACK_MAX_MS = 200;
    localparam int HPD_MAX_MS = 200;
    localparam int HPD_DELAY_MS = 20;
    localparam int VALID_MAX_MS = 50;
    localparam int VALID_QUAL_MS = 10;
    localparam int LOSS_MAX_MS = 50;
    localparam int LOSS_QUAL_MS = 5;
    // Source delays in milliseconds
    localparam int IDLE_MIN_MS = 1;
    localparam int BL_ON_MIN_MS = 1;
    localparam int LED_STEP_MS = 1;
    localparam int PWR_OFF_MAX_MS = 500;
    localparam int PWR_OFF_MS = 10;
    // Link status field
    localparam logic [19:0] SINK_STATUS_ADDR = 20'h00205;
    localparam int SINK_STATUS_BIT = 0;
    localparam int NO_VIDEO_BIT = 3;
    // Source register offsets and control bits
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam int CTRL_POWER = 0;
    localparam int CTRL_VIDEO = 1;
    localparam int CTRL_BL = 2;
endpackage : pps_pkg

// file: src/pps_link_if.sv
`timescale 1ns/10ps
// Link between source and sink sequencers
interface pps_link_if;
    logic panel_logic_supply;
    logic hpd;
    logic aux_req;
    logic aux_ack;
    logic train_done;
    logic video_valid;
    logic [7:0] vbid;
    logic sink_status;
    logic led_power;
    logic led_dim;
    logic led_enable;
    modport sink (input panel_logic_supply, aux_req, train_done, video_valid, vbid,
                  input led_power, led_dim, led_enable,
                  output hpd, aux_ack, sink_status);
    modport source (output panel_logic_supply, aux_req, train_done, video_valid, vbid,
                    output led_power, led_dim, led_enable,
                    input hpd, aux_ack, sink_status);
endinterface : pps_link_if

// file: src/pps_ms_timer.sv
`timescale 1ns/10ps
// Millisecond tick and a restartable ms counter
module pps_ms_timer #(
    parameter int TICK_CYCLES = pps_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control
    input wire logic restart,
    // Status
    output logic [9:0] elapsed_ms
);
    logic [16:0] div;
    logic [16:0] next_div;
    logic [9:0] next_elapsed_ms;

    // Saturating counter so long waits never wrap
    always_comb begin
        next_div = div;
        next_elapsed_ms = elapsed_ms;
        if (restart) begin
            next_div = '0;
            next_elapsed_ms = '0;
        end else if (div == 17'(TICK_CYCLES - 1)) begin
            next_div = '0;
            if (elapsed_ms != 10'h3ff) begin
                next_elapsed_ms = elapsed_ms + 10'h001;
            end
        end else begin
            next_div = div + 17'h00001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            div <= '0;
            elapsed_ms <= '0;
        end else begin
            div <= next_div;
            elapsed_ms <= next_elapsed_ms;
        end
    end
endmodule : pps_ms_timer

// file: src/pps_sink.sv
`timescale 1ns/10ps
// Functional notes
// - black video starts 0.5 to 200 ms
// - HPD high within 200 ms, AUX ready
// - tolerate early AUX polls, source retries
// - answer AUX within 200 ms
// - source reads capability then trains
// - source idles link 1 ms before video
// - show video within 50 ms, status set
// - source waits 1 ms before backlight
// - backlight dark before video ends
// - video end clears status, black video
// - source removes power within 500 ms
// - LED power 1 ms before dimming
// - dimming removed 1 ms before LED power
// - LED enable 1 ms after dimming
// - LED enable off 1 ms before dimming off
// - no-video flag forces black video
// - link loss gives black within 50 ms
// - invalid video judged from timing info
// - debug control disables auto black
module pps_sink #(
    parameter int TICK_CYCLES = pps_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Link
    pps_link_if.sink link,
    // Received stream qualifiers
    input wire logic msa_ok,
    input wire logic auto_black_dis,
    // Panel outputs
    output logic black_video,
    output logic video_shown,
    output logic aux_ready
);
    typedef enum logic [2:0] {
        PPS_OFF = 3'b000,
        PPS_WAKE = 3'b001,
        PPS_BLACK = 3'b011,
        PPS_QUAL = 3'b010,
        PPS_SHOW = 3'b110,
        PPS_LOSS = 3'b111
    } pps_sink_state_e;

    pps_sink_state_e state;
    pps_sink_state_e next_state;
    logic [1:0] sup_sync;
    logic [1:0] req_sync;
    logic [1:0] val_sync;
    logic [1:0] nov_sync;
    logic [1:0] msa_sync;
    logic [1:0] dis_sync;
    logic next_black_video;
    logic next_video_shown;
    logic next_aux_ready;
    logic next_hpd;
    logic next_aux_ack;
    logic restart;
    logic [9:0] ms;
    logic good;

    // Timer compare against a whole number of milliseconds
    function automatic logic ms_reached(input logic [9:0] elapsed, input int lim_ms);
        return elapsed >= 10'(lim_ms);
    endfunction : ms_reached

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, read only through the second stage
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sup_sync <= '0;
            req_sync <= '0;
            val_sync <= '0;
            nov_sync <= '0;
            msa_sync <= '0;
            dis_sync <= '0;
        end else begin
            sup_sync <= {sup_sync[0], link.panel_logic_supply};
            req_sync <= {req_sync[0], link.aux_req};
            val_sync <= {val_sync[0], link.video_valid};
            nov_sync <= {nov_sync[0], link.vbid[pps_pkg::NO_VIDEO_BIT]};
            msa_sync <= {msa_sync[0], msa_ok};
            dis_sync <= {dis_sync[0], auto_black_dis};
        end
    end

    // Video counts as good only with data, valid timing and no flag
    assign good = val_sync[1] && msa_sync[1] && !nov_sync[1];

    // Shared ms timer, restarted by every state that opens a wait
    pps_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .restart(restart),
        .elapsed_ms(ms)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Power-on and video qualification sequence
    always_comb begin
        next_state = state;
        restart = 1'b0;
        next_black_video = black_video;
        next_video_shown = video_shown;
        next_aux_ready = aux_ready;
        next_hpd = link.hpd;
        next_aux_ack = 1'b0;
        unique case (state)
            PPS_OFF: begin
                // Everything held off until the supply is seen steady
                next_black_video = 1'b0;
                next_video_shown = 1'b0;
                next_aux_ready = 1'b0;
                next_hpd = 1'b0;
                restart = 1'b1;
                if (sup_sync[1]) begin
                    next_state = PPS_WAKE;
                end
            end
            PPS_WAKE: begin
                // AUX brought up first so it is live before HPD rises
                if (ms_reached(ms, pps_pkg::BLACK_MIN_MS)) begin
                    next_black_video = 1'b1;
                    next_aux_ready = 1'b1;
                end
                if (ms_reached(ms, pps_pkg::HPD_DELAY_MS) && aux_ready) begin
                    next_hpd = 1'b1;
                    next_state = PPS_BLACK;
                end
            end
            PPS_BLACK: begin
                // Debug control may hold the last picture in place of black
                restart = 1'b1;
                next_black_video = !dis_sync[1];
                next_video_shown = 1'b0;
                if (good) begin
                    next_state = PPS_QUAL;
                end
            end
            PPS_QUAL: begin
                // Video must hold steady for the whole qualify window
                if (!good) begin
                    next_state = PPS_BLACK;
                end else if (ms_reached(ms, pps_pkg::VALID_QUAL_MS)) begin
                    next_video_shown = 1'b1;
                    next_black_video = 1'b0;
                    next_state = PPS_SHOW;
                end
            end
            PPS_SHOW: begin
                // Stream end or the no-video flag ends the picture at once
                restart = 1'b1;
                if (nov_sync[1] || !val_sync[1]) begin
                    next_video_shown = 1'b0;
                    next_black_video = !dis_sync[1];
                    next_state = PPS_BLACK;
                end else if (!msa_sync[1]) begin
                    next_state = PPS_LOSS;
                end
            end
            PPS_LOSS: begin
                // Short glitches ride through, long faults go black
                if (good) begin
                    next_state = PPS_SHOW;
                end else if (ms_reached(ms, pps_pkg::LOSS_QUAL_MS)) begin
                    next_video_shown = 1'b0;
                    next_black_video = !dis_sync[1];
                    next_state = PPS_BLACK;
                end
            end
            default: begin
                next_state = PPS_OFF;
            end
        endcase
        // Supply loss overrides every state
        if (!sup_sync[1]) begin
            next_state = PPS_OFF;
        end
        // Polls are answered once ready; earlier ones are silently dropped
        if (req_sync[1] && aux_ready && !link.aux_ack) begin
            next_aux_ack = 1'b1;
        end
    end

    // Registered outputs; the link status bit mirrors the shown flag
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= PPS_OFF;
            black_video <= 1'b0;
            video_shown <= 1'b0;
            aux_ready <= 1'b0;
            link.hpd <= 1'b0;
            link.aux_ack <= 1'b0;
            link.sink_status <= 1'b0;
        end else begin
            state <= next_state;
            black_video <= next_black_video;
            video_shown <= next_video_shown;
            aux_ready <= next_aux_ready;
            link.hpd <= next_hpd;
            link.aux_ack <= next_aux_ack;
            link.sink_status <= next_video_shown;
        end
    end
endmodule : pps_sink

// file: src/pps_source.sv
`timescale 1ns/10ps
// Video source sequencer with a small register port
module pps_source #(
    parameter int TICK_CYCLES = pps_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Link
    pps_link_if.source link,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    typedef enum logic [3:0] {
        SRC_OFF = 4'b0000,
        SRC_HPD = 4'b0001,
        SRC_IDLE = 4'b0011,
        SRC_VIDEO = 4'b0010,
        SRC_LEDP = 4'b0110,
        SRC_DIM = 4'b0111,
        SRC_ON = 4'b0101,
        SRC_DOWN_EN = 4'b0100,
        SRC_DOWN_DIM = 4'b1100,
        SRC_DOWN_P = 4'b1101,
        SRC_END = 4'b1111
    } pps_src_state_e;

    pps_src_state_e state;
    pps_src_state_e next_state;
    logic [2:0] ctrl;
    logic [2:0] next_ctrl;
    logic [31:0] next_reg_rdata;
    logic [1:0] hpd_sync;
    logic [1:0] ack_sync;
    logic [1:0] sts_sync;
    logic restart;
    logic [9:0] ms;
    logic n_sup, n_req, n_train, n_val, n_lp, n_dim, n_en, n_nov;

    // Step timer shared by every wait
    pps_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .restart(restart),
        .elapsed_ms(ms)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register port, read data one cycle after the strobe
    always_comb begin
        next_ctrl = ctrl;
        next_reg_rdata = '0;
        if (reg_wr && reg_addr == pps_pkg::REG_CTRL) begin
            next_ctrl = reg_wdata[2:0];
        end
        if (reg_rd && reg_addr == pps_pkg::REG_CTRL) begin
            next_reg_rdata = {29'h0, ctrl};
        end else if (reg_rd && reg_addr == pps_pkg::REG_STAT) begin
            next_reg_rdata = {23'h0, sts_sync[1], hpd_sync[1], link.led_enable,
                              link.video_valid, state, link.panel_logic_supply};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl <= '0;
            reg_rdata <= '0;
            hpd_sync <= '0;
            ack_sync <= '0;
            sts_sync <= '0;
        end else begin
            ctrl <= next_ctrl;
            reg_rdata <= next_reg_rdata;
            hpd_sync <= {hpd_sync[0], link.hpd};
            ack_sync <= {ack_sync[0], link.aux_ack};
            sts_sync <= {sts_sync[0], link.sink_status};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power, training, video and backlight ordering
    always_comb begin
        next_state = state;
        restart = 1'b0;
        n_sup = link.panel_logic_supply;
        n_req = 1'b0;
        n_train = link.train_done;
        n_val = link.video_valid;
        n_lp = link.led_power;
        n_dim = link.led_dim;
        n_en = link.led_enable;
        n_nov = link.vbid[pps_pkg::NO_VIDEO_BIT];
        unique case (state)
            SRC_OFF: begin
                restart = 1'b1;
                n_sup = 1'b0;
                n_train = 1'b0;
                n_nov = 1'b1;
                if (ctrl[pps_pkg::CTRL_POWER]) begin
                    n_sup = 1'b1;
                    next_state = SRC_HPD;
                end
            end
            SRC_HPD: begin
                // Poll repeatedly; unanswered polls are simply retried
                n_req = hpd_sync[1] && !ack_sync[1];
                if (hpd_sync[1] && ack_sync[1]) begin
                    n_train = 1'b1;
                    restart = 1'b1;
                    next_state = SRC_IDLE;
                end
            end
            SRC_IDLE: begin
                if (ms > 10'(pps_pkg::IDLE_MIN_MS) && ctrl[pps_pkg::CTRL_VIDEO]) begin
                    n_val = 1'b1;
                    n_nov = 1'b0;
                    restart = 1'b1;
                    next_state = SRC_VIDEO;
                end
            end
            SRC_VIDEO: begin
                if (ms > 10'(pps_pkg::BL_ON_MIN_MS) && ctrl[pps_pkg::CTRL_BL]) begin
                    n_lp = 1'b1;
                    restart = 1'b1;
                    next_state = SRC_LEDP;
                end
            end
            SRC_LEDP: begin
                if (ms > 10'(pps_pkg::LED_STEP_MS)) begin
                    n_dim = 1'b1;
                    restart = 1'b1;
                    next_state = SRC_DIM;
                end
            end
            SRC_DIM: begin
                if (ms > 10'(pps_pkg::LED_STEP_MS)) begin
                    n_en = 1'b1;
                    next_state = SRC_ON;
                end
            end
            SRC_ON: begin
                restart = 1'b1;
                if (!ctrl[pps_pkg::CTRL_BL] || !ctrl[pps_pkg::CTRL_VIDEO]
                    || !ctrl[pps_pkg::CTRL_POWER]) begin
                    n_en = 1'b0;
                    next_state = SRC_DOWN_EN;
                end
            end
            SRC_DOWN_EN: begin
                if (ms > 10'(pps_pkg::LED_STEP_MS)) begin
                    n_dim = 1'b0;
                    restart = 1'b1;
                    next_state = SRC_DOWN_DIM;
                end
            end
            SRC_DOWN_DIM: begin
                if (ms > 10'(pps_pkg::LED_STEP_MS)) begin
                    n_lp = 1'b0;
                    restart = 1'b1;
                    next_state = SRC_DOWN_P;
                end
            end
            SRC_DOWN_P: begin
                // Backlight fully off before the stream stops
                if (ms > 10'(pps_pkg::LED_STEP_MS)) begin
                    n_val = 1'b0;
                    n_nov = 1'b1;
                    restart = 1'b1;
                    next_state = SRC_END;
                end
            end
            SRC_END: begin
                if (ms >= 10'(pps_pkg::PWR_OFF_MS)) begin
                    n_sup = 1'b0;
                    n_train = 1'b0;
                    next_state = SRC_OFF;
                end
            end
            default: begin
                next_state = SRC_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= SRC_OFF;
            link.panel_logic_supply <= 1'b0;
            link.aux_req <= 1'b0;
            link.train_done <= 1'b0;
            link.video_valid <= 1'b0;
            link.vbid <= 8'h08;
            link.led_power <= 1'b0;
            link.led_dim <= 1'b0;
            link.led_enable <= 1'b0;
        end else begin
            state <= next_state;
            link.panel_logic_supply <= n_sup;
            link.aux_req <= n_req;
            link.train_done <= n_train;
            link.video_valid <= n_val;
            link.vbid <= {4'h0, n_nov, 3'h0};
            link.led_power <= n_lp;
            link.led_dim <= n_dim;
            link.led_enable <= n_en;
        end
    end
endmodule : pps_source

// file: testbench/pps_link_chk.sv
`timescale 1ns/10ps
// Timing watcher on the link between source and sink
module pps_link_chk #(
    parameter int TICK_CYCLES = pps_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Link
    input wire logic panel_logic_supply,
    input wire logic hpd,
    input wire logic aux_req,
    input wire logic aux_ack,
    input wire logic train_done,
    input wire logic video_valid,
    input wire logic [7:0] vbid,
    input wire logic sink_status,
    input wire logic led_power,
    input wire logic led_dim,
    input wire logic led_enable
);
    // One cycle is lost sampling the edge that opens each gap
    localparam int GAP = TICK_CYCLES - 1;
    localparam int HPD_LIM = pps_pkg::HPD_MAX_MS * TICK_CYCLES;
    localparam int VID_LIM = pps_pkg::VALID_MAX_MS * TICK_CYCLES;
    localparam int OFF_LIM = pps_pkg::PWR_OFF_MAX_MS * TICK_CYCLES;
    int sup_cnt, idle_cnt, vid_cnt, good_cnt, pwr_cnt, dim_cnt, en_off, dim_off, down_cnt;
    logic had_video;
    ////////////////////////////////////////////////////////////////////////////////
    // How long each condition has held, cleared by reset
    always_ff @(posedge sys_clk) begin
        sup_cnt <= (reset_n && panel_logic_supply) ? sup_cnt + 1 : 0;
        idle_cnt <= (reset_n && train_done && !video_valid) ? idle_cnt + 1 : 0;
        vid_cnt <= (reset_n && video_valid) ? vid_cnt + 1 : 0;
        // A status drop restarts qualification, so the deadline starts over
        good_cnt <= (reset_n && video_valid && !vbid[3] && !$fell(sink_status)) ?
            good_cnt + 1 : 0;
        pwr_cnt <= (reset_n && led_power) ? pwr_cnt + 1 : 0;
        dim_cnt <= (reset_n && led_dim) ? dim_cnt + 1 : 0;
        en_off <= (reset_n && !led_enable) ? en_off + 1 : 0;
        dim_off <= (reset_n && !led_dim) ? dim_off + 1 : 0;
        down_cnt <= (reset_n && panel_logic_supply && !video_valid && had_video) ?
            down_cnt + 1 : 0;
        had_video <= reset_n && panel_logic_supply && (had_video || video_valid);
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_hpd_deadline: assert property (sup_cnt >= HPD_LIM |-> hpd)
        else $error("hpd late after supply");
    chk_aux_answer: assert property ($rose(aux_req) && hpd |-> ##[1:8] aux_ack)
        else $error("poll after hpd not answered");
    chk_train_on_hpd: assert property ($rose(train_done) |-> hpd)
        else $error("training before hpd");
    chk_idle_gap: assert property ($rose(video_valid) |-> idle_cnt >= GAP)
        else $error("idle too short before video");
    chk_status_cause: assert property ($rose(sink_status) |-> video_valid && !vbid[3])
        else $error("status set without video");
    chk_status_deadline: assert property (good_cnt >= VID_LIM |-> sink_status)
        else $error("status late after video");
    chk_video_to_led: assert property ($rose(led_power) |-> vid_cnt >= GAP)
        else $error("backlight too soon after video");
    chk_dark_at_end: assert property ($fell(video_valid) |-> !led_enable && !led_power)
        else $error("video ended with backlight on");
    chk_status_clear: assert property ($fell(video_valid) |-> ##[1:6] !sink_status)
        else $error("status kept after video end");
    chk_power_removal: assert property (down_cnt <= OFF_LIM)
        else $error("supply kept too long");
    chk_power_to_dim: assert property ($rose(led_dim) |-> pwr_cnt >= GAP)
        else $error("dimming before led power settled");
    chk_dim_power_off: assert property ($fell(led_power) |-> dim_off >= GAP)
        else $error("led power removed too soon");
    chk_dim_to_enable: assert property ($rose(led_enable) |-> dim_cnt >= GAP)
        else $error("enable too soon after dimming");
    chk_enable_dim_off: assert property ($fell(led_dim) |-> en_off >= GAP)
        else $error("dimming removed too soon");
    chk_noflag_clear: assert property ($rose(vbid[3]) |-> ##[1:6] !sink_status)
        else $error("status kept after no-video flag");
    cover property ($rose(sink_status));
    cover property ($rose(led_enable));
    cover property ($fell(video_valid) ##[1:6] !sink_status);
endmodule : pps_link_chk

// file: testbench/panel_power_video_sequencer_test.sv
`timescale 1ns/10ps
// Full power cycle of source and sink joined by the link
module panel_power_video_sequencer_test;
    // Short tick keeps the run small; every delay scales with it
    localparam int MS = 20;
    logic sys_clk, reset_n, msa_ok, auto_black_dis, reg_wr, reg_rd;
    logic black_video, video_shown, aux_ready;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    int bad_count, n_checks, n, cyc, t0;
    pps_link_if link_if ();
    pps_source #(.TICK_CYCLES(MS)) pps_source_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .link(link_if),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    pps_sink #(.TICK_CYCLES(MS)) pps_sink_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .link(link_if),
        .msa_ok(msa_ok), .auto_black_dis(auto_black_dis), .black_video(black_video),
        .video_shown(video_shown), .aux_ready(aux_ready));
    pps_link_chk #(.TICK_CYCLES(MS)) pps_link_chk_inst (.sys_clk(sys_clk),
        .reset_n(reset_n), .panel_logic_supply(link_if.panel_logic_supply),
        .hpd(link_if.hpd), .aux_req(link_if.aux_req), .aux_ack(link_if.aux_ack),
        .train_done(link_if.train_done), .video_valid(link_if.video_valid),
        .vbid(link_if.vbid), .sink_status(link_if.sink_status),
        .led_power(link_if.led_power), .led_dim(link_if.led_dim),
        .led_enable(link_if.led_enable));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // One-cycle write strobe
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // Read strobe; data stand only in the following cycle
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read
    function automatic logic sig(input int s);
        case (s)
            0: return link_if.panel_logic_supply;
            1: return black_video;
            2: return link_if.hpd;
            3: return link_if.video_valid;
            4: return link_if.sink_status;
            5: return link_if.led_enable;
            default: return video_shown;
        endcase
    endfunction : sig
    // Bounded wait for a level; running out counts as a mismatch
    task automatic wait_lvl(input int s, input logic v, input int lim);
        n = 0;
        while (sig(s) !== v && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check({31'h0, sig(s)}, {31'h0, v});
    endtask : wait_lvl
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    // Any answer before the sink is ready would mean an early poll got through
    always @(negedge sys_clk) begin
        if (reset_n === 1'b1 && link_if.aux_ack === 1'b1) begin
            check({31'h0, aux_ready}, 32'h1);
        end
    end
    // The whole sequence needs about 80 ms of simulated time
    initial begin
        repeat (300 * MS) @(posedge sys_clk);
        bad_count++;
        test_done();
    end
    initial begin
        reset_n = 1'b0;
        msa_ok = 1'b1;
        auto_black_dis = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bad_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        check({24'h0, link_if.vbid}, 32'h8);
        reg_read(pps_pkg::REG_STAT, rd);
        check(rd & 32'h1e1, 32'h0);
        reg_write(4'h8, 32'h7);
        reg_read(4'h8, rd);
        check(rd, 32'h0);
        reg_read(pps_pkg::REG_CTRL, rd);
        check(rd & 32'h7, 32'h0);
        // Power up: black video no sooner than half a millisecond
        reg_write(pps_pkg::REG_CTRL, 32'h1);
        wait_lvl(0, 1'b1, 10 * MS);
        t0 = cyc;
        repeat (MS / 2 - 1) @(posedge sys_clk);
        #1;
        check({31'h0, black_video}, 32'h0);
        wait_lvl(1, 1'b1, 200 * MS);
        wait_lvl(2, 1'b1, 200 * MS);
        check({31'h0, (cyc - t0) <= 200 * MS}, 32'h1);
        check({31'h0, aux_ready}, 32'h1);
        // Video on, then the sink qualifies it
        reg_write(pps_pkg::REG_CTRL, 32'h3);
        wait_lvl(3, 1'b1, 50 * MS);
        wait_lvl(4, 1'b1, 50 * MS);
        check({30'h0, video_shown, black_video}, 32'h2);
        reg_write(pps_pkg::REG_CTRL, 32'h7);
        wait_lvl(5, 1'b1, 20 * MS);
        reg_read(pps_pkg::REG_STAT, rd);
        check(rd & 32'h1e1, 32'h1e1);
        // Debug control holds the picture while timing is bad
        @(posedge sys_clk);
        auto_black_dis <= 1'b1;
        msa_ok <= 1'b0;
        repeat (10 * MS) @(posedge sys_clk);
        #1;
        check({31'h0, black_video}, 32'h0);
        @(posedge sys_clk);
        auto_black_dis <= 1'b0;
        wait_lvl(1, 1'b1, 40 * MS);
        @(posedge sys_clk);
        msa_ok <= 1'b1;
        wait_lvl(6, 1'b1, 50 * MS);
        // Orderly shutdown from one write
        reg_write(pps_pkg::REG_CTRL, 32'h0);
        wait_lvl(5, 1'b0, 10 * MS);
        wait_lvl(3, 1'b0, 20 * MS);
        check({31'h0, link_if.led_power}, 32'h0);
        repeat (8) @(posedge sys_clk);
        #1;
        check({30'h0, link_if.sink_status, black_video}, 32'h1);
        check({24'h0, link_if.vbid}, 32'h8);
        wait_lvl(0, 1'b0, 500 * MS);
        test_done();
    end
endmodule : panel_power_video_sequencer_test
